// ### rxfc_defs.svh
/*
  constants for the receive flow controller: register offsets, field
  positions, reset values and timing figures.
  assumes inclusion by bare name; definitions only.
*/
`ifndef RXFC_DEFS_SVH
`define RXFC_DEFS_SVH

// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define RXFC_CFG_OFF        12'hac  // flow control configuration
`define RXFC_CTRL_OFF       12'hb8  // duplex, speed, pause time
`define RXFC_STAT_OFF       12'hbc  // live state, read only

// --------------------------------------------------------------------
// configuration fields
// --------------------------------------------------------------------
`define RXFC_HI_MSB         23
`define RXFC_HI_LSB         16
`define RXFC_LO_MSB         15
`define RXFC_LO_LSB         8
`define RXFC_DUR_MSB        7
`define RXFC_DUR_LSB        4
`define RXFC_MULT_BIT       3
`define RXFC_BRD_BIT        2
`define RXFC_ADD_BIT        1
`define RXFC_ANY_BIT        0
`define RXFC_CFG_MASK       32'h00ffffff
`define RXFC_CFG_RST        32'h00000000

// control fields: bit0 full duplex, bit1 10 Mb/s, 31:16 pause time
`define RXFC_FDX_BIT        0
`define RXFC_SLOW_BIT       1
`define RXFC_PT_MSB         31
`define RXFC_PT_LSB         16
`define RXFC_CTRL_MASK      32'hffff0003
`define RXFC_CTRL_RST       32'h00000000

// --------------------------------------------------------------------
// timing: 25 MHz clock, times in nanoseconds
// --------------------------------------------------------------------
`define RXFC_CLK_MHZ        25
`define RXFC_UNIT_BYTES_LOG 6     // thresholds count 64 byte units
`define RXFC_T5_NS          5000
`define RXFC_T10_NS         10000
`define RXFC_T15_NS         15000
`define RXFC_T25_NS         25000
`define RXFC_STEP_NS        50000 // codes 4..f: 50 us per step
`define RXFC_SLOW_ADD_NS    2200  // extra at 10 Mb/s
`define RXFC_NS_CYC(ns)     (((ns) * `RXFC_CLK_MHZ + 999) / 1000)

`endif

// ### rxfc_pkg.sv
/*
  types of the receive flow controller.
  assumes nothing beyond the constants header.
*/
package rxfc_pkg;
  // back pressure timer state, one-hot
  typedef enum logic [2:0] {
    RXFC_IDLE = 3'b001,
    RXFC_JAM  = 3'b010,
    RXFC_HOLD = 3'b100
  } rxfc_bp_state_t;
  typedef logic [15:0] rxfc_cnt_t;  // back pressure cycle count
endpackage

// ### rxfc_bp_timer.sv
/*
  back pressure duration timer: maps the 4-bit duration code and the
  link speed to a cycle count and holds jam for that long.
  assumes start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
`include "rxfc_defs.svh"
module rxfc_bp_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,     // begin a jam period
  input  wire logic [3:0] dur_sel,   // duration code
  input  wire logic       slow,      // 10 Mb/s link
  output logic            jam_reg    // back pressure active
);
  import rxfc_pkg::*;

  // --------------------------------------------------------------------
  // duration lookup
  // --------------------------------------------------------------------
  rxfc_cnt_t base_cyc;   // cycles at 100 Mb/s
  rxfc_cnt_t dur_cyc;    // cycles for current speed
  rxfc_cnt_t cnt_reg;    // remaining cycles
  logic [31:0] ns_val;   // chosen time in ns

  // code to time, then to cycles rounded up
  always_comb begin
    case (dur_sel)
      4'h0: ns_val = `RXFC_T5_NS;
      4'h1: ns_val = `RXFC_T10_NS;
      4'h2: ns_val = `RXFC_T15_NS;
      4'h3: ns_val = `RXFC_T25_NS;
      default: ns_val = 32'(dur_sel - 4'h3) * `RXFC_STEP_NS;
    endcase
    base_cyc = 16'(`RXFC_NS_CYC(ns_val));
    dur_cyc  = slow ? 16'(`RXFC_NS_CYC(ns_val + `RXFC_SLOW_ADD_NS))
                    : base_cyc;
  end

  // --------------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------------
  // jam for dur_cyc cycles after start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      jam_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= dur_cyc;
      jam_reg <= 1'b1;
    end else if (cnt_reg > 16'h0001) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end else begin
      cnt_reg <= 16'h0000;
      jam_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_jam_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> jam_reg) else $error("jam not raised after start");
  a_short_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && dur_sel == 4'h0 && !slow) |=> jam_reg [*8] ##118 !jam_reg)
    else $error("5 us jam length wrong");
endmodule

// ### rxfc_top.sv
/*
  receive flow controller of a 10/100 mac: compares rx fifo fill with
  programmed thresholds, jams in half duplex, requests pause frames in
  full duplex, any-frame mode only. registers over axi4-lite.
  assumes preamble and address-match strobes come from the rx mac on
  the same clock, and the tx side acknowledges each pause request.
*/
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rxfc_defs.svh"
module rxfc_top #(
  parameter int FILL_W = 14             // rx fifo byte count width
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // rx side
  input  wire logic [FILL_W-1:0] rx_fifo_bytes,   // fill level
  input  wire logic              rx_preamble,     // valid preamble seen
  input  wire logic              rx_dest_valid,   // dest decoded pulse
  input  wire logic              rx_is_mcast,
  input  wire logic              rx_is_bcast,
  input  wire logic              rx_is_own,
  input  wire logic              tx_enabled,      // transmitter on
  // tx side
  output logic                   backpressure_reg,
  output logic                   pause_req_reg,   // request, held to ack
  output logic [15:0]            pause_time_reg,
  input  wire logic              pause_ack
);
  import rxfc_pkg::*;

  // --------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------
  logic [31:0] cfg_reg;         // threshold and trigger configuration
  logic [31:0] ctrl_reg;        // duplex, speed, pause time
  logic        aw_hold_reg;     // write address taken
  logic        w_hold_reg;      // write data taken
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        above_reg;       // high level met in the previous cycle
  logic        paused_reg;      // non-zero pause sent, not resumed
  logic        jam_start;       // one-cycle jam trigger
  logic        jam_out;         // timer output
  logic        hi_met;
  logic        lo_under;
  logic        any_on;
  logic        fdx;
  logic        type_hit;
  logic        frame_hit;
  logic [FILL_W-1:0] units;     // fill in 64-byte units

  assign any_on = cfg_reg[`RXFC_ANY_BIT];
  assign fdx    = ctrl_reg[`RXFC_FDX_BIT];
  assign units  = rx_fifo_bytes >> `RXFC_UNIT_BYTES_LOG;

  // --------------------------------------------------------------------
  // threshold compare and frame trigger
  // --------------------------------------------------------------------
  // level comparison runs every cycle
  always_comb begin
    hi_met   = units >= FILL_W'(cfg_reg[`RXFC_HI_MSB:`RXFC_HI_LSB]);
    lo_under = units < FILL_W'(cfg_reg[`RXFC_LO_MSB:`RXFC_LO_LSB]);
    // filters by frame type, half duplex only
    type_hit = rx_dest_valid &&
               ((cfg_reg[`RXFC_MULT_BIT] && rx_is_mcast) ||
                (cfg_reg[`RXFC_BRD_BIT]  && rx_is_bcast) ||
                (cfg_reg[`RXFC_ADD_BIT]  && rx_is_own));
    // any-frame mode: preamble alone, no address decode
    frame_hit = any_on ? rx_preamble : (!fdx && type_hit);
  end

  // arm while the high level is met, one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      above_reg <= 1'b0;
    end else begin
      above_reg <= hi_met;
    end
  end

  // jam on each matching frame in half duplex
  assign jam_start = above_reg && frame_hit && !fdx && tx_enabled;

  rxfc_bp_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (jam_start),
    .dur_sel (cfg_reg[`RXFC_DUR_MSB:`RXFC_DUR_LSB]),
    .slow    (ctrl_reg[`RXFC_SLOW_BIT]),
    .jam_reg (jam_out)
  );

  // register the jam onto the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backpressure_reg <= 1'b0;
    end else begin
      backpressure_reg <= jam_out && !fdx;
    end
  end

  // --------------------------------------------------------------------
  // pause frame requests
  // --------------------------------------------------------------------
  // one pause at the first preamble above high, zero pause when below the low level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_req_reg  <= 1'b0;
      pause_time_reg <= 16'h0000;
      paused_reg     <= 1'b0;
    end else if (pause_req_reg) begin
      if (pause_ack) begin
        pause_req_reg <= 1'b0;               // request done
      end
    end else if (fdx && any_on && tx_enabled) begin
      if (!paused_reg && above_reg && rx_preamble) begin
        pause_req_reg  <= 1'b1;
        pause_time_reg <= ctrl_reg[`RXFC_PT_MSB:`RXFC_PT_LSB];
        paused_reg     <= 1'b1;
      end else if (paused_reg && lo_under) begin
        pause_req_reg  <= 1'b1;
        pause_time_reg <= 16'h0000;
        paused_reg     <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------
  // take address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else if (aw_hold_reg && w_hold_reg) begin
      if (!s_axi_bvalid) begin
        aw_hold_reg <= 1'b0;                 // commit cycle
        w_hold_reg  <= 1'b0;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
    end
  end

  // ready while slot empty and no response pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_reg && !s_axi_bvalid &&
                       !(s_axi_wvalid && s_axi_wready);
    end
  end

  // commit with byte strobes, answer okay or decerr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg      <= `RXFC_CFG_RST;
      ctrl_reg     <= `RXFC_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        if (wstrb_reg[i]) begin
          if (awaddr_reg[11:2] == `RXFC_CFG_OFF >> 2) begin
            cfg_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8] &
                                 8'(`RXFC_CFG_MASK >> (i*8));
          end
          if (awaddr_reg[11:2] == `RXFC_CTRL_OFF >> 2) begin
            ctrl_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8] &
                                  8'(`RXFC_CTRL_MASK >> (i*8));
          end
        end
      end
      if (awaddr_reg[11:2] != `RXFC_CFG_OFF >> 2 &&
          awaddr_reg[11:2] != `RXFC_CTRL_OFF >> 2) begin
        s_axi_bresp <= 2'b11;                // unmapped
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------
  // one read at a time, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'b00;
      case (s_axi_araddr[11:2])
        `RXFC_CFG_OFF >> 2:  s_axi_rdata <= cfg_reg;
        `RXFC_CTRL_OFF >> 2: s_axi_rdata <= ctrl_reg;
        `RXFC_STAT_OFF >> 2: s_axi_rdata <= {27'h0000000, backpressure_reg,
                                 pause_req_reg, paused_reg, above_reg,
                                 hi_met};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b11;              // unmapped
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_any_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    (fdx && any_on && tx_enabled && above_reg && !paused_reg &&
     rx_preamble && !pause_req_reg) |=> pause_req_reg && paused_reg)
    else $error("no pause at preamble");
  a_fdx_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pause_req_reg) |-> $past(any_on) && $past(fdx))
    else $error("pause without any-frame");
  a_hdx_jam: assert property (@(posedge aclk) disable iff (!aresetn)
    (!fdx && any_on && above_reg && rx_preamble && tx_enabled)
    |=> ##1 backpressure_reg) else $error("no jam at preamble");
  a_filter_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (any_on && !rx_preamble) |-> !jam_start)
    else $error("type filter acted in any mode");
  a_single_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(pause_req_reg) && pause_time_reg != 16'h0000) |->
    paused_reg)
    else $error("pause flag not set");
  a_zero_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(pause_req_reg) && pause_time_reg == 16'h0000) |->
    $past(paused_reg) && !paused_reg)
    else $error("zero pause without prior pause");
  a_arm_level: assert property (@(posedge aclk) disable iff (!aresetn)
    hi_met |=> above_reg) else $error("high level not armed");
  a_trig_any: assert property (@(posedge aclk) disable iff (!aresetn)
    (above_reg && any_on && rx_preamble && !fdx && tx_enabled)
    |-> jam_start) else $error("any frame ignored");
  a_no_jam_fdx: assert property (@(posedge aclk) disable iff (!aresetn)
    fdx |=> !backpressure_reg) else $error("jam in full duplex");
  a_unit_scale: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_fifo_bytes < FILL_W'({cfg_reg[`RXFC_HI_MSB:`RXFC_HI_LSB], 6'h00}))
    |-> !hi_met) else $error("threshold scaling wrong");

  c_pause:  cover property (@(posedge aclk) $rose(pause_req_reg));
  c_resume: cover property (@(posedge aclk)
    $rose(pause_req_reg) && pause_time_reg == 16'h0000);
  c_jam:    cover property (@(posedge aclk) $rose(backpressure_reg));
endmodule

// ### rxfc_tx_model.sv
/*
  stand-in for the pause transmitter toward the remote station:
  accepts each pause request after a chosen delay, records it.
  assumes the request is held until the acknowledge pulse.
*/
`timescale 1ns/1ns
module rxfc_tx_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        pause_req_reg,
  input  wire logic [15:0] pause_time_reg,
  input  wire logic [3:0]  ack_dly,    // wait before accepting
  output logic             pause_ack,  // one-cycle accept
  output logic [7:0]       pause_cnt,  // frames accepted
  output logic [15:0]      last_time   // time of last frame
);
  // ------------------------------------------------------------
  // accept logic
  // ------------------------------------------------------------
  logic [3:0] wait_reg;  // cycles waited on this request

  // pulse after the delay; record the frame on the accept edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_ack <= 1'b0;
      pause_cnt <= 8'h00;
      last_time <= 16'h0000;
      wait_reg  <= 4'h0;
    end else if (pause_ack) begin
      pause_ack <= 1'b0;
      pause_cnt <= pause_cnt + 8'h01;
      last_time <= pause_time_reg;
      wait_reg  <= 4'h0;
    end else if (pause_req_reg) begin
      if (wait_reg >= ack_dly) begin
        pause_ack <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// ### rxfc_top_tb.sv
/*
  self-checking bench of the receive flow controller.
  assumes the register map of the constants header and a pause
  transmitter that answers each request.
*/
`timescale 1ns/1ns
`include "rxfc_defs.svh"
module rxfc_top_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] fill;          // rx fifo byte count
  logic        pre, dvld, mc, bc, own;
  logic        bp, preq, pack;
  logic [15:0] ptime, ltime;
  logic [7:0]  pcnt;          // pauses seen at the far side
  logic [3:0]  dly;           // far side accept delay
  int          num_errors, cmp_count, cyc;

  rxfc_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_fifo_bytes(fill),
    .rx_preamble(pre), .rx_dest_valid(dvld), .rx_is_mcast(mc),
    .rx_is_bcast(bc), .rx_is_own(own), .tx_enabled(1'b1),
    .backpressure_reg(bp), .pause_req_reg(preq),
    .pause_time_reg(ptime), .pause_ack(pack));

  rxfc_tx_model far (.aclk(aclk), .aresetn(aresetn),
    .pause_req_reg(preq), .pause_time_reg(ptime), .ack_dly(dly),
    .pause_ack(pack), .pause_cnt(pcnt), .last_time(ltime));

  // clock and hang guard
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      results();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task results();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // value compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // axi4-lite write, each channel released at its own handshake
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, 32'h00000000);
  endtask

  // axi4-lite read, data taken at the rvalid edge
  task rd(input logic [11:0] a, output logic [31:0] d,
          output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one-cycle frame start
  task frame();
    @(posedge aclk);
    pre <= 1'b1;
    @(posedge aclk);
    pre <= 1'b0;
  endtask

  // reset values, mask of the config word, unmapped place
  task t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`RXFC_CFG_OFF, d, r);
    chk(d, 32'h00000000);
    chk({30'h0, r}, 32'h00000000);
    rd(`RXFC_CTRL_OFF, d, r);
    chk(d, 32'h00000000);
    wr(`RXFC_CFG_OFF, 32'hffffffff);
    rd(`RXFC_CFG_OFF, d, r);
    chk(d, 32'h00ffffff);
    rd(12'hf00, d, r);
    chk({30'h0, r}, 32'h00000003);
    chk(d, 32'h00000000);
    wr(`RXFC_CFG_OFF, 32'h00000000);
  endtask

  // full duplex: threshold edge, single pause, zero pause
  task t_fdx();
    dly <= 4'h3;
    wr(`RXFC_CTRL_OFF, 32'h12340001);
    wr(`RXFC_CFG_OFF, 32'h00020101);
    fill <= 14'd127;
    idle(3);
    frame();
    idle(20);
    chk({24'h0, pcnt}, 32'h00000000);
    fill <= 14'd128;
    idle(3);
    frame();
    idle(20);
    chk({24'h0, pcnt}, 32'h00000001);
    chk({16'h0, ltime}, 32'h00001234);
    chk({31'h0, bp}, 32'h00000000);
    frame();
    idle(20);
    chk({24'h0, pcnt}, 32'h00000001);
    fill <= 14'd64;
    idle(20);
    chk({24'h0, pcnt}, 32'h00000001);
    dly <= 4'h0;
    fill <= 14'd63;
    idle(20);
    chk({24'h0, pcnt}, 32'h00000002);
    chk({16'h0, ltime}, 32'h00000000);
  endtask

  // full duplex, type bits only: no pause on any frame
  task t_nofc();
    wr(`RXFC_CFG_OFF, 32'h0002010e);
    fill <= 14'd200;
    idle(3);
    frame();
    @(posedge aclk);
    dvld <= 1'b1;
    mc   <= 1'b1;
    bc   <= 1'b1;
    own  <= 1'b1;
    @(posedge aclk);
    dvld <= 1'b0;
    idle(20);
    chk({24'h0, pcnt}, 32'h00000002);
    chk({31'h0, bp}, 32'h00000000);
  endtask

  // half duplex, multicast bit only: preamble alone no jam
  task t_type();
    wr(`RXFC_CTRL_OFF, 32'h00000000);
    wr(`RXFC_CFG_OFF, 32'h00020108);
    fill <= 14'd128;
    idle(3);
    frame();
    idle(5);
    chk({31'h0, bp}, 32'h00000000);
    @(posedge aclk);
    dvld <= 1'b1;
    mc   <= 1'b1;
    @(posedge aclk);
    dvld <= 1'b0;
    mc   <= 1'b0;
    idle(5);
    chk({31'h0, bp}, 32'h00000001);
    idle(200);
  endtask

  // half duplex: jam at preamble for the coded time
  task t_hdx(input logic [3:0] c, input logic slow);
    int ns, k, n;
    ns = (c < 4) ? ((c == 3) ? 25000 : 5000 * (c + 1))
                 : 50000 * (c - 3);
    if (slow) ns = ns + 2200;
    wr(`RXFC_CTRL_OFF, {30'h0, slow, 1'b0});
    wr(`RXFC_CFG_OFF, {16'h0201, c, 4'h1});
    fill <= 14'd128;
    idle(3);
    frame();
    k = 0;
    while (bp !== 1'b1 && k < 10) begin
      @(posedge aclk);
      k++;
    end
    n = 0;
    while (bp === 1'b1 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    chk(n, (ns * 25 + 999) / 1000);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    cyc = 0;
    num_errors = 0;
    cmp_count = 0;
    aresetn <= 1'b0;
    {awaddr, araddr, wdata} <= '0;
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    {pre, dvld, mc, bc, own} <= '0;
    fill <= '0;
    dly  <= 4'h0;
    idle(6);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_fdx();
    t_nofc();
    for (int c = 0; c < 5; c++) begin
      t_hdx(c[3:0], 1'b0);
    end
    t_hdx(4'h0, 1'b1);
    t_hdx(4'hf, 1'b1);
    t_type();
    results();
  end
endmodule
